// ### rtl/mes_status_regs.sv
// read-only estimator status bank on the device register port
// assumes the algorithm drives values and update strobes on ref_clk,
// and the register port issues one read or write per cycle
`default_nettype none

module mes_status_regs #(
    parameter int ADDR_W = mes_pkg::ADDR_W,
    parameter int DATA_W = mes_pkg::DATA_W
) (
    input  wire logic                        ref_clk,           // device clock, 100 MHz
    input  wire logic                        rst_n,             // synchronous reset, active low
    // register port
    input  wire logic [ADDR_W-1:0]           reg_addr,          // word address
    input  wire logic                        reg_rd,            // read strobe
    input  wire logic                        reg_wr,            // write strobe
    input  wire logic [DATA_W-1:0]           reg_wdata,         // write data, discarded
    output logic      [DATA_W-1:0]           reg_rdata,         // read data
    output logic                             reg_rvalid,        // read answer pulse
    output logic                             reg_addr_err,      // unmapped access pulse
    output logic                             reg_wr_ignored,    // write refused pulse
    // algorithm side
    input  wire logic                        phase_upd,         // new probe phase
    input  wire logic [mes_pkg::PHASE_W-1:0] phase_in,          // probe phase code
    input  wire logic                        init_angle_upd,    // new initial angle
    input  wire logic [DATA_W-1:0]           init_angle_in,     // initial angle value
    input  wire logic                        bemf_d_upd,        // new d-axis back-emf
    input  wire logic [DATA_W-1:0]           bemf_d_in,         // d-axis back-emf value
    input  wire logic                        bemf_q_upd,        // new q-axis back-emf
    input  wire logic [DATA_W-1:0]           bemf_q_in,         // q-axis back-emf value
    input  wire logic                        speed_upd,         // new speed estimate
    input  wire logic [DATA_W-1:0]           speed_in,          // speed estimate value
    input  wire logic                        rotor_angle_upd,   // new rotor angle
    input  wire logic [DATA_W-1:0]           rotor_angle_in,    // rotor angle value
    // decoded probe status
    output logic                             probe_done,        // phase is complete
    output logic                             probe_error        // phase is fault
);
    localparam int N = mes_pkg::NUM_REGS;

    // per-slot load strobes, inputs and held values
    logic [N-1:0]        slot_load;
    logic [DATA_W-1:0]   slot_din   [0:N-1];
    logic [DATA_W-1:0]   slot_dout  [0:N-1];
    logic [N-1:0]        slot_hit;
    logic [DATA_W-1:0]   slot_mask  [0:N-1];
    logic [DATA_W-1:0]   mux_acc    [0:N];

    // port side state
    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    logic                rvalid_r;
    logic                addr_err_r;
    logic                addr_err_nxt;
    logic                wr_ign_r;
    logic                done_r;
    logic                done_nxt;
    logic                error_r;
    logic                error_nxt;

    // phase codes beyond the fault code are never stored
    logic                phase_code_ok;
    logic [DATA_W-1:0]   phase_wide;
    logic                any_hit;
    logic [DATA_W-1:0]   wdata_unused;

    assign phase_code_ok = (phase_in <= mes_pkg::PHASE_ERROR);
    assign phase_wide    = {{(DATA_W-mes_pkg::PHASE_W){1'b0}}, phase_in};
    assign wdata_unused  = reg_wdata;

    // slot inputs in address-table order
    assign slot_load[mes_pkg::IDX_PROBE_PHASE]   = phase_upd & phase_code_ok;
    assign slot_load[mes_pkg::IDX_INITIAL_ANGLE] = init_angle_upd;
    assign slot_load[mes_pkg::IDX_BEMF_D]        = bemf_d_upd;
    assign slot_load[mes_pkg::IDX_BEMF_Q]        = bemf_q_upd;
    assign slot_load[mes_pkg::IDX_ROTOR_SPEED]   = speed_upd;
    assign slot_load[mes_pkg::IDX_ROTOR_ANGLE]   = rotor_angle_upd;

    assign slot_din[mes_pkg::IDX_PROBE_PHASE]   = phase_wide;
    assign slot_din[mes_pkg::IDX_INITIAL_ANGLE] = init_angle_in;
    assign slot_din[mes_pkg::IDX_BEMF_D]        = bemf_d_in;
    assign slot_din[mes_pkg::IDX_BEMF_Q]        = bemf_q_in;
    assign slot_din[mes_pkg::IDX_ROTOR_SPEED]   = speed_in;
    assign slot_din[mes_pkg::IDX_ROTOR_ANGLE]   = rotor_angle_in;

    assign mux_acc[0] = '0;

    // one holder, one decoder and one mux stage per slot
    for (genvar i = 0; i < N; i++) begin : g_slot
        mes_value_reg #(
            .WIDTH (DATA_W)
        ) u_value (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .load    (slot_load[i]),
            .din     (slot_din[i]),
            .dout    (slot_dout[i])
        );
        assign slot_hit[i]   = (reg_addr == mes_pkg::ADDR_TABLE[i]);
        assign slot_mask[i]  = slot_hit[i] ? slot_dout[i] : '0;
        assign mux_acc[i+1]  = mux_acc[i] | slot_mask[i];
    end

    // read answer: whole word sampled in one edge, unmapped reads zero
    assign any_hit      = |slot_hit;
    assign rdata_nxt    = reg_rd ? mux_acc[N] : rdata_r;
    assign addr_err_nxt = (reg_rd | reg_wr) & ~any_hit;

    // decoded status from the phase value about to be held
    assign done_nxt  = slot_load[mes_pkg::IDX_PROBE_PHASE]
                     ? (phase_in == mes_pkg::PHASE_DONE)
                     : done_r;
    assign error_nxt = slot_load[mes_pkg::IDX_PROBE_PHASE]
                     ? (phase_in == mes_pkg::PHASE_ERROR)
                     : error_r;

    // read data and answer strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r    <= mes_pkg::RESET_VALUE;
            rvalid_r   <= 1'b0;
            addr_err_r <= 1'b0;
            wr_ign_r   <= 1'b0;
        end else begin
            rdata_r    <= rdata_nxt;
            rvalid_r   <= reg_rd;
            addr_err_r <= addr_err_nxt;
            wr_ign_r   <= reg_wr;
        end
    end

    // probe status flags
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_r  <= 1'b0;
            error_r <= 1'b0;
        end else begin
            done_r  <= done_nxt;
            error_r <= error_nxt;
        end
    end

    assign reg_rdata      = rdata_r;
    assign reg_rvalid     = rvalid_r;
    assign reg_addr_err   = addr_err_r;
    assign reg_wr_ignored = wr_ign_r;
    assign probe_done     = done_r;
    assign probe_error    = error_r;

    // every read is answered exactly one cycle later
    a_read_answer_time: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
        else $error("read answer not on the next cycle");

    // no answer without a read
    a_no_spurious_answer: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid)
        else $error("read answer without a read");

    // reset clears every held value and the read data
    a_reset_clears_bank: assert property (
        @(posedge ref_clk)
        !rst_n |=> (slot_dout[0] == '0) && (slot_dout[1] == '0)
                && (slot_dout[2] == '0) && (slot_dout[3] == '0)
                && (slot_dout[4] == '0) && (slot_dout[5] == '0)
                && (reg_rdata == '0) && !reg_rvalid)
        else $error("bank not cleared by reset");

    // held phase never leaves the code range and upper bits stay zero
    a_phase_code_range: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (slot_dout[mes_pkg::IDX_PROBE_PHASE] <= 32'h0000000C))
        else $error("probe phase out of code range");

    // an invalid phase code leaves the stored phase unchanged
    a_phase_bad_held: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (phase_upd && (phase_in > mes_pkg::PHASE_ERROR))
        |=> $stable(slot_dout[mes_pkg::IDX_PROBE_PHASE]))
        else $error("invalid phase code was stored");

    // reading the initial angle returns the value held at the read
    a_init_angle_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_INITIAL_ANGLE)
        |=> reg_rdata == $past(slot_dout[mes_pkg::IDX_INITIAL_ANGLE]))
        else $error("initial angle read mismatch");

    // back-emf d is published one edge after its strobe
    a_bemf_d_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bemf_d_upd |=> slot_dout[mes_pkg::IDX_BEMF_D] == $past(bemf_d_in))
        else $error("d-axis back-emf not updated");

    // reading back-emf q returns the held value
    a_bemf_q_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_BEMF_Q)
        |=> reg_rdata == $past(slot_dout[mes_pkg::IDX_BEMF_Q]))
        else $error("q-axis back-emf read mismatch");

    // speed estimate reads the value present at the read edge
    a_speed_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_ROTOR_SPEED && speed_upd)
        |=> reg_rdata != $past(speed_in) || reg_rdata == $past(slot_dout[4]))
        else $error("speed read not a coherent snapshot");

    // rotor angle read data stands until the next read
    a_rotor_angle_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_ROTOR_ANGLE) ##1 !reg_rd
        |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // a write alone changes no held initial angle, back-emf d or rotor angle
    a_write_no_effect: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && slot_load == '0)
        |=> $stable(slot_dout[1]) && $stable(slot_dout[2]) && $stable(slot_dout[5])
            ##0 reg_wr_ignored)
        else $error("write touched a read-only register");

    // unmapped reads return zero and flag the error
    a_unmapped_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && !any_hit) |=> (reg_rdata == '0) && reg_addr_err)
        else $error("unmapped read not zero");

    // done and fault flags follow the held phase
    a_probe_flags_tie: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (probe_done == (slot_dout[0] == 32'h0000000B))
        && (probe_error == (slot_dout[0] == 32'h0000000C)))
        else $error("probe flags disagree with phase");

    // every write is answered by the refusal pulse
    a_write_flag_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_wr
        |=> reg_wr_ignored)
        else $error("write not flagged as ignored");

    // no refusal pulse without a write
    a_no_write_flag: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !reg_wr
        |=> !reg_wr_ignored)
        else $error("refusal pulse without a write");

    // mapped accesses and idle cycles raise no address error
    a_mapped_no_error: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !((reg_rd || reg_wr) && !any_hit)
        |=> !reg_addr_err)
        else $error("address error on a mapped access");

    // a legal phase code is held one edge after its strobe
    a_phase_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (phase_upd && (phase_in <= mes_pkg::PHASE_ERROR))
        |=> slot_dout[mes_pkg::IDX_PROBE_PHASE] == {16'h0000, $past(phase_in)})
        else $error("probe phase not stored");

    // reading the probe phase returns the held value
    a_phase_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_PROBE_PHASE)
        |=> reg_rdata == $past(slot_dout[mes_pkg::IDX_PROBE_PHASE]))
        else $error("probe phase read mismatch");

    // initial angle is published one edge after its strobe
    a_init_angle_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        init_angle_upd
        |=> slot_dout[mes_pkg::IDX_INITIAL_ANGLE] == $past(init_angle_in))
        else $error("initial angle not updated");

    // reading back-emf d returns the held value
    a_bemf_d_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_BEMF_D)
        |=> reg_rdata == $past(slot_dout[mes_pkg::IDX_BEMF_D]))
        else $error("d-axis back-emf read mismatch");

    // back-emf q is published one edge after its strobe
    a_bemf_q_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bemf_q_upd
        |=> slot_dout[mes_pkg::IDX_BEMF_Q] == $past(bemf_q_in))
        else $error("q-axis back-emf not updated");

    // speed estimate is published one edge after its strobe
    a_speed_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        speed_upd
        |=> slot_dout[mes_pkg::IDX_ROTOR_SPEED] == $past(speed_in))
        else $error("speed estimate not updated");

    // speed estimate holds while no strobe comes
    a_speed_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !speed_upd
        |=> $stable(slot_dout[mes_pkg::IDX_ROTOR_SPEED]))
        else $error("speed estimate changed without a strobe");

    // rotor angle is published one edge after its strobe
    a_rotor_angle_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rotor_angle_upd
        |=> slot_dout[mes_pkg::IDX_ROTOR_ANGLE] == $past(rotor_angle_in))
        else $error("rotor angle not updated");

    // reading the rotor angle returns the held value
    a_rotor_angle_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == mes_pkg::ADDR_ROTOR_ANGLE)
        |=> reg_rdata == $past(slot_dout[mes_pkg::IDX_ROTOR_ANGLE]))
        else $error("rotor angle read mismatch");
endmodule // mes_status_regs

`default_nettype wire

// ### rtl/mes_pkg.sv
// constants of the motor estimator status register bank
// assumes a 12-bit word address space on the device register port
// Function
// - probe phase reported in 16 bits, 0h..Ch
// - initial rotor angle, 32-bit, 2^27 per 360 degrees
// - d-axis back-emf estimate, 32-bit read-only
// - q-axis back-emf estimate, same scaling as d
// - rotor speed estimate, scaled by maximum speed
// - rotor angle estimate, 2^27 per 360 degrees
// - all cleared on reset, at fixed addresses
`default_nettype none

package mes_pkg;
    // register port geometry
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int PHASE_W  = 16;
    localparam int NUM_REGS = 6;

    // word addresses in the algorithm variable space
    localparam logic [ADDR_W-1:0] ADDR_PROBE_PHASE   = 12'h6B8;
    localparam logic [ADDR_W-1:0] ADDR_INITIAL_ANGLE = 12'h6FC;
    localparam logic [ADDR_W-1:0] ADDR_BEMF_D        = 12'h742;
    localparam logic [ADDR_W-1:0] ADDR_BEMF_Q        = 12'h744;
    localparam logic [ADDR_W-1:0] ADDR_ROTOR_SPEED   = 12'h752;
    localparam logic [ADDR_W-1:0] ADDR_ROTOR_ANGLE   = 12'h756;

    // slot index of each value inside the bank
    localparam int IDX_PROBE_PHASE   = 0;
    localparam int IDX_INITIAL_ANGLE = 1;
    localparam int IDX_BEMF_D        = 2;
    localparam int IDX_BEMF_Q        = 3;
    localparam int IDX_ROTOR_SPEED   = 4;
    localparam int IDX_ROTOR_ANGLE   = 5;

    // address table in slot order
    localparam logic [ADDR_W-1:0] ADDR_TABLE [0:NUM_REGS-1] = '{
        ADDR_PROBE_PHASE, ADDR_INITIAL_ANGLE, ADDR_BEMF_D,
        ADDR_BEMF_Q, ADDR_ROTOR_SPEED, ADDR_ROTOR_ANGLE
    };

    // reset value of every register
    localparam logic [DATA_W-1:0] RESET_VALUE = 32'h00000000;

    // fixed point scaling: full scale is two to this power
    localparam int FRAC_BITS = 27;

    // probe sequencer phase codes
    localparam logic [PHASE_W-1:0] PHASE_INIT          = 16'h0000;
    localparam logic [PHASE_W-1:0] PHASE_VECTOR_CONFIG = 16'h0001;
    localparam logic [PHASE_W-1:0] PHASE_RUN           = 16'h0002;
    localparam logic [PHASE_W-1:0] PHASE_SLOW_RISE     = 16'h0003;
    localparam logic [PHASE_W-1:0] PHASE_SLOW_FALL     = 16'h0004;
    localparam logic [PHASE_W-1:0] PHASE_DECAY_WAIT    = 16'h0005;
    localparam logic [PHASE_W-1:0] PHASE_GET_TIMES     = 16'h0006;
    localparam logic [PHASE_W-1:0] PHASE_NEXT_VECTOR   = 16'h0007;
    localparam logic [PHASE_W-1:0] PHASE_SECTOR_CALC   = 16'h0008;
    localparam logic [PHASE_W-1:0] PHASE_POSITION_CALC = 16'h0009;
    localparam logic [PHASE_W-1:0] PHASE_ANGLE_CALC    = 16'h000A;
    localparam logic [PHASE_W-1:0] PHASE_DONE          = 16'h000B;
    localparam logic [PHASE_W-1:0] PHASE_ERROR         = 16'h000C;
endpackage : mes_pkg

`default_nettype wire

// ### rtl/mes_value_reg.sv
// one status value holder: cleared on reset, loaded from the algorithm
// assumes a synchronous active-low reset and a single clock
`default_nettype none

module mes_value_reg #(
    parameter int WIDTH = 32
) (
    input  wire logic             ref_clk,  // device clock
    input  wire logic             rst_n,    // synchronous reset, active low
    input  wire logic             load,     // take din this edge
    input  wire logic [WIDTH-1:0] din,      // new value from the algorithm
    output var  logic [WIDTH-1:0] dout      // held value
);
    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;

    // hold unless the algorithm publishes a new value
    assign value_nxt = load ? din : value_r;

    // storage, cleared on reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            value_r <= '0;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign dout = value_r;
endmodule // mes_value_reg

`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the estimator status register bank
// assumes mes_pkg is compiled first; the bench drives every port itself
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        ref_clk, rst_n, reg_rd, reg_wr;
    logic [mes_pkg::ADDR_W-1:0]  reg_addr;
    logic [31:0]                 reg_wdata, init_angle_in, bemf_d_in, bemf_q_in;
    logic [31:0]                 speed_in, rotor_angle_in, v;
    logic [mes_pkg::PHASE_W-1:0] phase_in;
    logic                        phase_upd, init_angle_upd, bemf_d_upd, bemf_q_upd;
    logic                        speed_upd, rotor_angle_upd;
    wire logic [31:0]            reg_rdata;
    wire logic                   reg_rvalid, reg_addr_err, reg_wr_ignored;
    wire logic                   probe_done, probe_error;
    logic [32:0]                 exp_q [$];     // {addr_err, rdata} per read
    logic [31:0]                 exp_v [0:5];   // expected held values
    int                          err_count, check_count, seed_val;

    mes_status_regs dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_addr_err(reg_addr_err),
        .reg_wr_ignored(reg_wr_ignored), .phase_upd(phase_upd), .phase_in(phase_in),
        .init_angle_upd(init_angle_upd), .init_angle_in(init_angle_in),
        .bemf_d_upd(bemf_d_upd), .bemf_d_in(bemf_d_in), .bemf_q_upd(bemf_q_upd),
        .bemf_q_in(bemf_q_in), .speed_upd(speed_upd), .speed_in(speed_in),
        .rotor_angle_upd(rotor_angle_upd), .rotor_angle_in(rotor_angle_in),
        .probe_done(probe_done), .probe_error(probe_error)
    );

    // free-running 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic end_of_test();
        if (exp_q.size() != 0) err_count++;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc();
        @(negedge ref_clk);
    endtask

    // drop all strobes and let one cycle pass
    task automatic idle();
        {reg_rd, reg_wr, phase_upd, init_angle_upd} = 4'h0;
        {bemf_d_upd, bemf_q_upd, speed_upd, rotor_angle_upd} = 4'h0;
        @(negedge ref_clk);
    endtask

    // one read, expectation queued for the monitor
    task automatic rd(input logic [mes_pkg::ADDR_W-1:0] a, input logic [32:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        @(negedge ref_clk);
    endtask

    // raise one algorithm strobe with its value, no wait
    task automatic set_val(input int i, input logic [31:0] d);
        case (i)
            0: begin phase_upd = 1'b1; phase_in = d[15:0]; end
            1: begin init_angle_upd = 1'b1; init_angle_in = d; end
            2: begin bemf_d_upd = 1'b1; bemf_d_in = d; end
            3: begin bemf_q_upd = 1'b1; bemf_q_in = d; end
            4: begin speed_upd = 1'b1; speed_in = d; end
            default: begin rotor_angle_upd = 1'b1; rotor_angle_in = d; end
        endcase
    endtask

    task automatic read_all(input logic [31:0] dummy);
        for (int i = 0; i < 6; i++) rd(mes_pkg::ADDR_TABLE[i], {1'b0, exp_v[i]});
        idle();
    endtask

    // monitor: every read answer against the oldest queued note
    always @(negedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("wrong value at %0t: unexpected read answer", $time);
            end else begin
                chk(reg_rdata, exp_q[0][31:0]); // read data
                chk(reg_addr_err, exp_q[0][32]); // unmapped flag
                void'(exp_q.pop_front());
            end
        end
    end

    // watchdog against a hang
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial begin
        {rst_n, reg_rd, reg_wr, phase_upd, init_angle_upd} = 5'h00;
        {bemf_d_upd, bemf_q_upd, speed_upd, rotor_angle_upd} = 4'h0;
        {reg_addr, phase_in} = 28'h0000000;
        {reg_wdata, init_angle_in, bemf_d_in} = 96'h0;
        {bemf_q_in, speed_in, rotor_angle_in} = 96'h0;
        err_count = 0;
        check_count = 0;
        seed_val = $urandom(61);
        for (int i = 0; i < 6; i++) exp_v[i] = mes_pkg::RESET_VALUE;
        repeat (5) cyc();
        rst_n = 1'b1;
        // reset values of the whole bank
        read_all(32'h0);
        chk(probe_done, 1'b0);
        // every probe phase code and its decoded flags
        for (int c = 0; c < 13; c++) begin
            set_val(0, c);
            exp_v[0] = c;
            cyc();
            idle();
            rd(mes_pkg::ADDR_PROBE_PHASE, {1'b0, exp_v[0]});
            idle();
            chk(probe_done, c == 11);
            chk(probe_error, c == 12);
        end
        // code above the range is dropped
        set_val(0, 32'h0000FFFD);
        cyc();
        idle();
        rd(mes_pkg::ADDR_PROBE_PHASE, {1'b0, exp_v[0]});
        idle();
        chk(probe_error, 1'b1);
        // random values, back-to-back updates and reads
        for (int i = 1; i < 6; i++) begin
            v = $urandom;
            set_val(i, v);
            exp_v[i] = v;
            cyc();
        end
        idle();
        read_all(32'h0);
        // writes to every register and one unmapped place
        for (int i = 0; i < 7; i++) begin
            reg_wr = 1'b1;
            reg_addr = (i < 6) ? mes_pkg::ADDR_TABLE[i] : 12'h6FE;
            reg_wdata = $urandom;
            cyc();
            chk(reg_wr_ignored, 1'b1);
            chk(reg_addr_err, i == 6);
        end
        idle();
        read_all(32'h0);
        rd(12'h6FE, {1'b1, 32'h0});
        idle();
        // read and write in one cycle: read answered, write dropped
        reg_wr = 1'b1;
        rd(mes_pkg::ADDR_BEMF_Q, {1'b0, exp_v[3]});
        chk(reg_wr_ignored, 1'b1);
        idle();
        chk(reg_wr_ignored, 1'b0);
        // update and read in the same cycle return the old word
        v = $urandom;
        set_val(4, v);
        rd(mes_pkg::ADDR_ROTOR_SPEED, {1'b0, exp_v[4]});
        exp_v[4] = v;
        idle();
        rd(mes_pkg::ADDR_ROTOR_SPEED, {1'b0, exp_v[4]});
        idle();
        // reset in mid-run clears everything
        rst_n = 1'b0;
        cyc();
        cyc();
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) exp_v[i] = mes_pkg::RESET_VALUE;
        read_all(32'h0);
        chk(probe_error, 1'b0);
        repeat (2) idle();
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
